// ### rtl/skp_map.svh
// Constants for the conditional-skip execution block.
// Assumes one include per compile unit; guarded anyway.
`ifndef SKP_MAP_SVH
`define SKP_MAP_SVH

// ----------------------------------------------------------------
// Opcodes (ten-bit words)
// ----------------------------------------------------------------
`define SKP_OP_IRQ1_LEVEL   10'h03B
`define SKP_OP_POWERDOWN    10'h003

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SKP_IRQ1_SEL_BIT    2
`define SKP_OPCODE_RST      10'h000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SKP_CYCLES_PER_INSN 1

`endif

// ### rtl/skp_pkg.sv
// Types shared by the conditional-skip execution block.
// Assumes skp_map.svh supplies numeric constants.
package skp_pkg;

  typedef logic [9:0] skp_word_t;

  // Instruction presented by the sequencer for one machine cycle
  typedef struct packed {
    logic      valid;
    skp_word_t opcode;
  } skp_insn_s;

  // Verdict on the instruction that follows
  typedef struct packed {
    logic done;
    logic skip;
  } skp_verdict_s;

  typedef enum logic [1:0] {
    SKP_KIND_NONE,
    SKP_KIND_IRQ1,
    SKP_KIND_PDOWN
  } skp_kind_e;

endpackage

// ### rtl/skp_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to i_ref_clk.
`timescale 1ns/10ps
module skp_pin_sync
  import skp_pkg::*;
(
  input  wire logic i_ref_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_pin,
  output logic      o_level
);

  logic [2:0] stg_q;
  logic [2:0] stg_d;
  logic       lvl_q;
  logic       lvl_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Stage 0 feeds only stage 1; the level moves when 1 and 2 agree
  always_comb begin
    stg_d = {stg_q[1:0], i_pin};
    lvl_d = lvl_q;
    if (stg_q[1] == stg_q[2]) begin
      lvl_d = stg_q[2];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      stg_q <= 3'h0;
      lvl_q <= 1'b0;
    end else begin
      stg_q <= stg_d;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;

endmodule

// ### rtl/skp_exec.sv
// Execution of two conditional-skip instructions of a 4-bit core.
// Assumes the sequencer presents one decoded word per machine cycle
// and honours o_skip_next on the instruction that follows.
// The pin reaches the verdict four cycles after it settles; a
// glitch shorter than one cycle never reaches it.
// Flags are only mirrored: this block has no path that alters them.
//
// How it works
// - Select 0: pin-level opcode skips next when irq pin one is low.
// - Select 1: pin-level opcode skips next when irq pin one is high.
// - Select 0 and pin high: next instruction executes normally.
// - Select 1 and pin low: next instruction executes normally.
// - Power-down opcode skips when flag is 1; flag left untouched.
// - Power-down opcode with flag 0: next instruction executes.
`include "skp_map.svh"
`timescale 1ns/10ps
module skp_exec
  import skp_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_insn_valid,
  input  wire logic [9:0] i_opcode,
  input  wire logic       i_ext_irq_pin_one,
  input  wire logic [3:0] i_second_irq_control_reg,
  input  wire logic       i_powerdown_flag,
  input  wire logic       i_carry_flag,
  output logic            o_done,
  output logic            o_skip_next,
  output logic            o_carry_flag,
  output logic            o_powerdown_flag
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  function automatic skp_kind_e decode(input skp_insn_s insn);
    decode = SKP_KIND_NONE;
    if (insn.valid) begin
      case (insn.opcode)
        `SKP_OP_IRQ1_LEVEL: decode = SKP_KIND_IRQ1;
        `SKP_OP_POWERDOWN:  decode = SKP_KIND_PDOWN;
        default:            decode = SKP_KIND_NONE;
      endcase
    end
  endfunction

  skp_insn_s    insn;
  skp_kind_e    kind;
  logic         pin_lvl;
  logic         irq1_level_select;
  skp_verdict_s vd_q;
  skp_verdict_s vd_d;
  logic         carry_q;
  logic         carry_d;
  logic         pd_q;
  logic         pd_d;

  assign insn              = '{valid: i_insn_valid, opcode: i_opcode};
  assign kind              = decode(insn);
  assign irq1_level_select = i_second_irq_control_reg[`SKP_IRQ1_SEL_BIT];

  // The pin is outside the core clock; filtered before it is tested
  skp_pin_sync u_sync (
    .i_ref_clk (i_ref_clk),
    .i_sys_rst (i_sys_rst),
    .i_pin     (i_ext_irq_pin_one),
    .o_level   (pin_lvl)
  );

  // ----------------------------------------------------------------
  // Verdict
  // ----------------------------------------------------------------
  always_comb begin
    vd_d = '{done: 1'b0, skip: 1'b0};
    // single cycle
    // Every recognised opcode finishes in the cycle it is taken
    case (kind)
      SKP_KIND_IRQ1: begin
        vd_d.done = 1'b1;
        vd_d.skip = (pin_lvl == irq1_level_select);
      end
      SKP_KIND_PDOWN: begin
        vd_d.done = 1'b1;
        vd_d.skip = i_powerdown_flag;
      end
      default: begin
        vd_d = '{done: 1'b0, skip: 1'b0};
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      vd_q <= '{done: 1'b0, skip: 1'b0};
    end else begin
      vd_q <= vd_d;
    end
  end

  // ----------------------------------------------------------------
  // Flag mirrors
  // ----------------------------------------------------------------
  always_comb begin
    // carry untouched
    // Neither opcode has a path that could write the carry
    carry_d = i_carry_flag;
    // flag kept
    // Flag is only mirrored, never cleared by the test
    pd_d    = i_powerdown_flag;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      carry_q <= 1'b0;
      pd_q    <= 1'b0;
    end else begin
      carry_q <= carry_d;
      pd_q    <= pd_d;
    end
  end

  assign o_done           = vd_q.done;
  assign o_skip_next      = vd_q.skip;
  assign o_carry_flag     = carry_q;
  assign o_powerdown_flag = pd_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_IRQ1_SEL0_LOW: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_IRQ1 && !irq1_level_select && !pin_lvl)
      |=> (o_done && o_skip_next))
    else $error("pin low with select 0 did not skip");

  AST_IRQ1_SEL1_HIGH: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_IRQ1 && irq1_level_select && pin_lvl)
      |=> (o_done && o_skip_next))
    else $error("pin high with select 1 did not skip");

  AST_IRQ1_SEL0_HIGH: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_IRQ1 && !irq1_level_select && pin_lvl)
      |=> (o_done && !o_skip_next))
    else $error("pin high with select 0 skipped");

  AST_IRQ1_SEL1_LOW: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_IRQ1 && irq1_level_select && !pin_lvl)
      |=> (o_done && !o_skip_next))
    else $error("pin low with select 1 skipped");

  AST_PDOWN_SKIP: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_PDOWN && i_powerdown_flag)
      |=> (o_done && o_skip_next && o_powerdown_flag))
    else $error("power-down flag set but no skip or flag lost");

  AST_PDOWN_EXEC: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_PDOWN && !i_powerdown_flag)
      |=> (o_done && !o_skip_next))
    else $error("power-down flag clear but skipped");

  AST_CARRY_KEPT: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind != SKP_KIND_NONE) |=> (o_carry_flag == $past(i_carry_flag)))
    else $error("carry flag disturbed by skip opcode");

  AST_ONE_CYCLE: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_insn_valid && (i_opcode == `SKP_OP_IRQ1_LEVEL
      || i_opcode == `SKP_OP_POWERDOWN)) ##1 !i_insn_valid
      |=> !o_done)
    else $error("skip opcode took more than one cycle");

  AST_NO_SKIP_OTHERS: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_NONE) |=> (!o_done && !o_skip_next))
    else $error("unrelated opcode produced a verdict");

  AST_PIN_FILTER: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    $changed(pin_lvl) |-> (pin_lvl == $past(u_sync.stg_q[2])))
    else $error("pin level changed without agreement");

  AST_PIN_AGREE: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    $changed(pin_lvl)
      |-> ($past(u_sync.stg_q[1]) == $past(u_sync.stg_q[2])))
    else $error("pin level moved before two stages agreed");

  AST_PDOWN_CLEAR_KEPT: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_PDOWN && !i_powerdown_flag)
      |=> !o_powerdown_flag)
    else $error("power-down flag clear but shown set");

  AST_PDOWN_FLAG_KEPT: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    (kind == SKP_KIND_PDOWN)
      |=> (o_powerdown_flag == $past(i_powerdown_flag)))
    else $error("power-down flag altered by its skip test");

  AST_CARRY_ALWAYS: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    !i_sys_rst |=> (o_carry_flag == $past(i_carry_flag)))
    else $error("carry flag mirror lost its value");

  AST_SKIP_WITH_DONE: assert property (
    @(posedge i_ref_clk) disable iff (i_sys_rst)
    o_skip_next |-> o_done)
    else $error("skip verdict shown without a finished opcode");

  AST_RESET_QUIET: assert property (
    @(posedge i_ref_clk)
    i_sys_rst |=> (!o_done && !o_skip_next
      && !o_carry_flag && !o_powerdown_flag))
    else $error("outputs not cleared by reset");

endmodule

// ### tb/tb_top.sv
// Self-checking bench for the conditional-skip execution block.
// Assumes the design's own assertions run alongside.
`timescale 1ns/10ps
module tb_top;
  logic       i_ref_clk = 1'b0;
  logic       i_sys_rst = 1'b1;
  logic       i_insn_valid = 1'b0;
  logic [9:0] i_opcode = 10'h000;
  logic       i_ext_irq_pin_one = 1'b0;
  logic [3:0] i_second_irq_control_reg = 4'h0;
  logic       i_powerdown_flag = 1'b0;
  logic       i_carry_flag = 1'b0;
  logic       o_done;
  logic       o_skip_next;
  logic       o_carry_flag;
  logic       o_powerdown_flag;
  int         bad_count = 0;
  int         num_checks = 0;
  int         cyc = 0;

  skp_exec dut (
    .i_ref_clk                (i_ref_clk),
    .i_sys_rst                (i_sys_rst),
    .i_insn_valid             (i_insn_valid),
    .i_opcode                 (i_opcode),
    .i_ext_irq_pin_one        (i_ext_irq_pin_one),
    .i_second_irq_control_reg (i_second_irq_control_reg),
    .i_powerdown_flag         (i_powerdown_flag),
    .i_carry_flag             (i_carry_flag),
    .o_done                   (o_done),
    .o_skip_next              (o_skip_next),
    .o_carry_flag             (o_carry_flag),
    .o_powerdown_flag         (o_powerdown_flag)
  );

  always #25 i_ref_clk = ~i_ref_clk;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs well under 2000 cycles
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic chk(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %b want %b", $time, msg, got, exp);
    end
  endtask

  // Present one word, then look just after the edge that takes it
  task automatic issue(input logic [9:0] op, input logic vld);
    @(posedge i_ref_clk);
    i_insn_valid <= vld;
    i_opcode     <= op;
    @(posedge i_ref_clk);
    i_insn_valid <= 1'b0;
    #1;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_pin();
    for (int k = 0; k < 4; k++) begin
      @(posedge i_ref_clk);
      i_second_irq_control_reg <= k[1] ? 4'h4 : 4'hB;
      i_ext_irq_pin_one        <= k[0];
      // Pin passes a synchroniser, so let it settle first
      repeat (6) @(posedge i_ref_clk);
      issue(10'h03B, 1'b1);
      chk(o_done, 1'b1, "pin test done");
      chk(o_skip_next, k[0] == k[1], "pin verdict");
    end
    $display("pin level test finished");
  endtask

  task automatic test_pdown();
    for (int k = 0; k < 2; k++) begin
      @(posedge i_ref_clk);
      i_powerdown_flag <= k[0];
      issue(10'h003, 1'b1);
      chk(o_done, 1'b1, "pd test done");
      chk(o_skip_next, k[0], "pd verdict");
      chk(o_powerdown_flag, k[0], "pd flag kept");
      chk(o_carry_flag, 1'b0, "pd carry kept");
    end
    $display("power-down test finished");
  endtask

  task automatic test_other();
    logic [9:0] ops [3] = '{10'h03A, 10'h001, 10'h13B};
    @(posedge i_ref_clk);
    i_powerdown_flag <= 1'b1;
    i_carry_flag     <= 1'b1;
    foreach (ops[i]) begin
      issue(ops[i], 1'b1);
      chk(o_done, 1'b0, "foreign word done");
      chk(o_skip_next, 1'b0, "foreign word skip");
    end
    issue(10'h003, 1'b0);
    chk(o_done, 1'b0, "invalid word done");
    chk(o_carry_flag, 1'b1, "carry kept");
    $display("foreign word test finished");
  endtask

  // Pin test then flag test in adjacent cycles
  task automatic test_back();
    // Select is still 1; drop the pin and let it settle
    @(posedge i_ref_clk);
    i_ext_irq_pin_one <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    i_insn_valid <= 1'b1;
    i_opcode     <= 10'h03B;
    @(posedge i_ref_clk);
    i_opcode     <= 10'h003;
    #1;
    chk(o_done, 1'b1, "b2b first done");
    chk(o_skip_next, 1'b0, "b2b pin verdict");
    @(posedge i_ref_clk);
    i_insn_valid <= 1'b0;
    #1;
    chk(o_done, 1'b1, "b2b second done");
    chk(o_skip_next, 1'b1, "b2b pd verdict");
    chk(o_carry_flag, 1'b1, "b2b carry kept");
    $display("back-to-back test finished");
  endtask

  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    #1;
    chk(o_done, 1'b0, "reset done");
    chk(o_skip_next, 1'b0, "reset skip");
    test_pin();
    test_pdown();
    test_other();
    test_back();
    test_done();
  end
endmodule
